// ===== hw/rate_match_pcs.sv
module rate_match_pcs
  import rate_match_pkg::*;
#(
  parameter int DEPTH = rate_match_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic arst_n, // async reset, active low
  input wire logic lowlat_en, // low-latency bypass select
  input wire logic width_10b, // 1: 10-bit interface, 0: 8-bit
  input wire logic [rate_match_pkg::SYM_W-1:0] skip_sym, // skip pattern {k,byte}
  input wire logic in_valid, // link-side word valid
  output logic in_ready, // link-side accept
  input wire logic [rate_match_pkg::WORD_W-1:0] in_word, // link-side word
  output logic out_valid, // fabric word valid
  input wire logic out_ready, // fabric accept
  output logic [rate_match_pkg::WORD_W-1:0] out_word, // fabric word
  output logic rm_full, // full flag with this word
  output logic rm_empty, // empty flag with this word
  input wire logic tx_elec_idle, // transmitter electrical idle request
  output logic tx_drv_oe, // differential driver enable
  input wire logic sig_det_en, // signal detect enable
  input wire logic sig_det_raw, // raw threshold detector
  output logic sig_det // qualified signal detect
);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < START_LVL || DEPTH <= HIGH_WM) begin : g_chk
    $error("rate_match_pcs depth too small for the fill levels");
  end

  // mask to the selected interface width
  function automatic logic [WORD_W-1:0] mask_word(input logic [WORD_W-1:0] w,
                                                 input logic wide);
    mask_word = wide ? w : {2'h0, w[7:0]};
  endfunction : mask_word

  // ****************************************************************
  // write side: deletion and full handling
  // ****************************************************************
  logic f_wvalid, f_wready, f_rvalid, f_rready;
  logic [SYM_W:0] f_rdata;
  logic [CW-1:0] f_count;
  logic wr_en, is_skip, del_w, drop_w;
  logic [2:0] kept_r, kept_nxt, del_r, del_nxt;
  logic full_pend_r, full_pend_nxt;

  always_comb begin
    wr_en = in_valid && !lowlat_en && f_wready;
    is_skip = (in_word[SYM_W-1:0] == skip_sym);
    del_w = wr_en && is_skip && (kept_r != 3'h0) && (del_r < MAX_DEL) &&
            (f_count >= CW'(HIGH_WM));
    drop_w = wr_en && !del_w && (f_count == CW'(DEPTH - 1));
    f_wvalid = wr_en && !del_w && !drop_w;
    kept_nxt = kept_r;
    del_nxt = del_r;
    if (wr_en) begin
      if (!is_skip) begin
        kept_nxt = 3'h0;
        del_nxt = 3'h0;
      end else if (del_w) begin
        del_nxt = 3'(del_r + 1'b1);
      end else if (kept_r != 3'h7) begin
        kept_nxt = 3'(kept_r + 1'b1);
      end
    end
    // flag the next byte, a new drop wins over clearing
    full_pend_nxt = full_pend_r;
    if (drop_w) begin
      full_pend_nxt = 1'b1;
    end else if (f_wvalid) begin
      full_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      kept_r <= 3'h0;
      del_r <= 3'h0;
      full_pend_r <= 1'b0;
    end else begin
      kept_r <= kept_nxt;
      del_r <= del_nxt;
      full_pend_r <= full_pend_nxt;
    end
  end

  sym_fifo #(
    .WIDTH(SYM_W + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .w_valid(f_wvalid),
    .w_ready(f_wready),
    .w_data({full_pend_r, in_word[SYM_W-1:0]}),
    .r_valid(f_rvalid),
    .r_ready(f_rready),
    .r_data(f_rdata),
    .count(f_count)
  );

  // ****************************************************************
  // read side: output stage, insertion and empty handling
  // ****************************************************************
  out_state_t st_r, st_nxt;
  logic take, ins_w, last_skip_r, last_skip_nxt;
  logic [2:0] oclus_r, oclus_nxt, oins_r, oins_nxt;
  logic ov_r, ov_nxt, full_r, full_nxt, empty_r, empty_nxt;
  logic [WORD_W-1:0] ow_r, ow_nxt;

  always_comb begin
    take = out_ready || !ov_r;
    ins_w = (st_r == ST_RUN) && take && last_skip_r && (f_count < CW'(LOW_WM)) &&
            (oclus_r < INS_CLUS_LIM) && (oins_r < MAX_INS);
    f_rready = (st_r == ST_RUN) && take && !ins_w && !lowlat_en;
    st_nxt = st_r;
    ov_nxt = ov_r;
    ow_nxt = ow_r;
    full_nxt = full_r;
    empty_nxt = empty_r;
    last_skip_nxt = last_skip_r;
    oclus_nxt = oclus_r;
    oins_nxt = oins_r;
    if (take) begin
      ov_nxt = 1'b0;
      full_nxt = 1'b0;
      empty_nxt = 1'b0;
    end
    if (lowlat_en) begin
      st_nxt = ST_FILL;
      last_skip_nxt = 1'b0;
      if (take && in_valid) begin
        ov_nxt = 1'b1;
        ow_nxt = mask_word(in_word, width_10b);
      end
    end else begin
      case (st_r)
        ST_FILL: begin
          if (f_count >= CW'(START_LVL)) begin
            st_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          if (ins_w) begin
            ov_nxt = 1'b1;
            ow_nxt = {1'b0, skip_sym};
            oclus_nxt = 3'(oclus_r + 1'b1);
            oins_nxt = 3'(oins_r + 1'b1);
          end else if (f_rready && f_rvalid) begin
            ov_nxt = 1'b1;
            ow_nxt = {1'b0, f_rdata[SYM_W-1:0]};
            full_nxt = f_rdata[SYM_W];
            last_skip_nxt = (f_rdata[SYM_W-1:0] == skip_sym);
            oclus_nxt = last_skip_nxt ? 3'(oclus_r + 1'b1) : 3'h0;
            if (!last_skip_nxt) begin
              oins_nxt = 3'h0;
            end
            // last entry leaves, fill character follows
            if (f_count == CW'(1) && !f_wvalid) begin
              st_nxt = ST_INS;
            end
          end
        end
        ST_INS: begin
          if (take) begin
            ov_nxt = 1'b1;
            ow_nxt = {1'b0, SYM_EMPTY_FILL};
            empty_nxt = 1'b1;
            last_skip_nxt = 1'b0;
            oclus_nxt = 3'h0;
            oins_nxt = 3'h0;
            st_nxt = ST_FILL;
          end
        end
        default: begin
          st_nxt = ST_FILL;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_FILL;
      ov_r <= 1'b0;
      ow_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b0;
      last_skip_r <= 1'b0;
      oclus_r <= 3'h0;
      oins_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      ov_r <= ov_nxt;
      ow_r <= ow_nxt;
      full_r <= full_nxt;
      empty_r <= empty_nxt;
      last_skip_r <= last_skip_nxt;
      oclus_r <= oclus_nxt;
      oins_r <= oins_nxt;
    end
  end

  // ****************************************************************
  // transmitter idle and signal detect
  // ****************************************************************
  logic oe_r, oe_nxt, sd_r, sd_nxt;

  always_comb begin
    oe_nxt = !tx_elec_idle;
    // detect qualified only with the coding stage active
    sd_nxt = sig_det_raw && sig_det_en && !lowlat_en;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oe_r <= 1'b0;
      sd_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt;
      sd_r <= sd_nxt;
    end
  end

  assign in_ready = lowlat_en ? take : f_wready;
  assign out_valid = ov_r;
  assign out_word = ow_r;
  assign rm_full = full_r;
  assign rm_empty = empty_r;
  assign tx_drv_oe = oe_r;
  assign sig_det = sd_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_del_bound;
    @(posedge clk_sys) disable iff (!arst_n)
    del_w |-> (kept_r >= 3'h1) && (del_r <= 3'h3) && !f_wvalid;
  endproperty
  a_del_bound: assert property (p_del_bound) else $error("skip deletion out of bounds");

  property p_ins_bound;
    @(posedge clk_sys) disable iff (!arst_n)
    ins_w |=> ov_r && (ow_r[SYM_W-1:0] == skip_sym) && (oins_r <= 3'h4) && (oclus_r <= 3'h5);
  endproperty
  a_ins_bound: assert property (p_ins_bound) else $error("skip insertion out of bounds");

  property p_full_drop;
    @(posedge clk_sys) disable iff (!arst_n)
    drop_w |-> !f_wvalid ##1 full_pend_r;
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("full byte not dropped");

  property p_empty_fill;
    @(posedge clk_sys) disable iff (!arst_n)
    (st_r == ST_RUN && f_rready && f_rvalid && f_count == CW'(1) && !f_wvalid && !lowlat_en)
    ##1 (out_ready && !lowlat_en) |=> ov_r && empty_r && (ow_r[SYM_W-1:0] == SYM_EMPTY_FILL);
  endproperty
  a_empty_fill: assert property (p_empty_fill) else $error("empty fill missing");

  property p_bypass;
    @(posedge clk_sys) disable iff (!arst_n)
    (lowlat_en && in_valid && take) |=> ov_r && !rm_full && !rm_empty &&
    (ow_r == mask_word($past(in_word), $past(width_10b)));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass word wrong");

  property p_idle_drv;
    @(posedge clk_sys) disable iff (!arst_n)
    tx_elec_idle |=> !tx_drv_oe;
  endproperty
  a_idle_drv: assert property (p_idle_drv) else $error("driver on in idle");

  property p_narrow;
    @(posedge clk_sys) disable iff (!arst_n)
    (lowlat_en && !width_10b && in_valid && take) |=> (ow_r[9:8] == 2'h0);
  endproperty
  a_narrow: assert property (p_narrow) else $error("8-bit word has high bits");

  property p_flag_clear;
    @(posedge clk_sys) disable iff (!arst_n)
    (rm_empty && out_ready) |=> !rm_empty;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("empty flag stuck");

  c_delete: cover property (@(posedge clk_sys) disable iff (!arst_n) del_w);
  c_insert: cover property (@(posedge clk_sys) disable iff (!arst_n) ins_w);
  c_drop: cover property (@(posedge clk_sys) disable iff (!arst_n) drop_w);
  c_empty: cover property (@(posedge clk_sys) disable iff (!arst_n) rm_empty);
endmodule : rate_match_pcs

// ===== hw/rate_match_pkg.sv
// Overview of operation
// - delete at most four skips per cluster, only after an earlier skip of it was stored or dropped.
// - insert at most four skips per cluster, only while it holds under five.
// - a byte that would fill the FIFO is dropped; full flags the next byte.
// - draining to empty appends 9'h1fe, flagged empty with that character.
// - low-latency mode bypasses coding, alignment, rate match and byte ordering.
// - transmitter electrical idle turns the differential driver off.
// - the serializer side interface is 8 or 10 bits wide, selectable in low-latency mode only.
package rate_match_pkg;
  // ****************************************************************
  // widths and depths
  // ****************************************************************
  localparam int SYM_W = 9;
  localparam int WORD_W = 10;
  localparam int FIFO_DEPTH = 16;
  // ****************************************************************
  // symbols and cluster limits
  // ****************************************************************
  localparam logic [8:0] SYM_EMPTY_FILL = 9'h1fe;
  localparam logic [2:0] MAX_DEL = 3'h4;
  localparam logic [2:0] MAX_INS = 3'h4;
  localparam logic [2:0] INS_CLUS_LIM = 3'h5;
  // ****************************************************************
  // fill levels
  // ****************************************************************
  localparam int HIGH_WM = 12;
  localparam int LOW_WM = 4;
  localparam int START_LVL = 8;
  // ****************************************************************
  // output stage states, gray along fill, run, insert
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_FILL = 2'h0,
    ST_RUN = 2'h1,
    ST_INS = 2'h3
  } out_state_t;
endpackage : rate_match_pkg

// ===== hw/sym_fifo.sv
module sym_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic w_valid, // write request
  output logic w_ready, // space available
  input wire logic [WIDTH-1:0] w_data, // write word
  output logic r_valid, // word available
  input wire logic r_ready, // read accept
  output logic [WIDTH-1:0] r_data, // head word
  output logic [$clog2(DEPTH+1)-1:0] count // fill level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("sym_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic do_wr, do_rd;

  // ****************************************************************
  // pointer and level update
  // ****************************************************************
  always_comb begin
    do_wr = w_valid && w_ready;
    do_rd = r_valid && r_ready;
    wp_nxt = do_wr ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt = do_rd ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = CW'(cnt_r + CW'(do_wr) - CW'(do_rd));
  end

  // registers only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem_r[wp_r] <= w_data;
    end
  end

  assign w_ready = (cnt_r != CW'(DEPTH));
  assign r_valid = (cnt_r != '0);
  assign r_data = mem_r[rp_r];
  assign count = cnt_r;
endmodule : sym_fifo

// ===== test/link_model.sv
module link_model (
  input wire logic clk_sys, // system clock
  input wire logic in_ready, // block accepts link word
  input wire logic out_valid, // block offers fabric word
  input wire logic [rate_match_pkg::WORD_W-1:0] out_word, // fabric word
  input wire logic rm_full, // full flag with word
  input wire logic rm_empty, // empty flag with word
  output logic in_valid, // link word valid
  output logic [rate_match_pkg::WORD_W-1:0] in_word, // link word
  output logic out_ready // fabric accept
);
  timeunit 1ns;
  timeprecision 1ps;
  import rate_match_pkg::*;
  // ****************************************************************
  // fabric side: stall control and word collector
  // ****************************************************************
  logic stall = 1'b1; // bench clears it to let words drain
  logic [11:0] got[$]; // {empty, full, word} per accepted word
  initial begin
    in_valid = 1'b0;
    in_word = '0;
    out_ready = 1'b0;
  end
  // accept follows stall, changed off the sampling edge
  always @(negedge clk_sys) out_ready <= !stall;
  // record each accepted word with its flags
  always @(posedge clk_sys) begin
    if (out_valid && out_ready) got.push_back({rm_empty, rm_full, out_word});
  end
  // ****************************************************************
  // link side: hold a word until the block takes it
  // ****************************************************************
  task automatic send(input logic [9:0] w);
    int k;
    @(negedge clk_sys);
    in_valid <= 1'b1;
    in_word <= w;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (in_ready) break;
    end
  endtask : send
  // released line shows the inverse, never the stale word
  task automatic release_link();
    @(negedge clk_sys);
    in_valid <= 1'b0;
    in_word <= ~in_word;
  endtask : release_link
endmodule : link_model

// ===== test/basic_mode_pcs_rate_match_bench.sv
module basic_mode_pcs_rate_match_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rate_match_pkg::*;
  localparam logic [8:0] SKIP = 9'h11c;
  logic clk_sys, arst_n, lowlat_en, width_10b, in_valid, in_ready, out_valid, out_ready;
  logic rm_full, rm_empty, tx_elec_idle, tx_drv_oe, sig_det_en, sig_det_raw, sig_det;
  logic [WORD_W-1:0] in_word, out_word;
  int n_fail, checked, cyc, n, nf;
  rate_match_pcs #(.DEPTH(FIFO_DEPTH)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .lowlat_en(lowlat_en), .width_10b(width_10b), .skip_sym(SKIP), .in_valid(in_valid),
    .in_ready(in_ready), .in_word(in_word), .out_valid(out_valid), .out_ready(out_ready),
    .out_word(out_word), .rm_full(rm_full), .rm_empty(rm_empty),
    .tx_elec_idle(tx_elec_idle), .tx_drv_oe(tx_drv_oe), .sig_det_en(sig_det_en),
    .sig_det_raw(sig_det_raw), .sig_det(sig_det));
  link_model i_link (.clk_sys(clk_sys), .in_ready(in_ready), .out_valid(out_valid),
    .out_word(out_word), .rm_full(rm_full), .rm_empty(rm_empty), .in_valid(in_valid),
    .in_word(in_word), .out_ready(out_ready));
  // ****************************************************************
  // clock and hang guard
  // ****************************************************************
  // one synchronous clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ****************************************************************
  // compare and close
  // ****************************************************************
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_idle();
    check(12'(tx_drv_oe), 12'h1);
    tx_elec_idle = 1'b1;
    @(negedge clk_sys);
    check(12'(tx_drv_oe), 12'h0);
    tx_elec_idle = 1'b0;
    @(negedge clk_sys);
    check(12'(tx_drv_oe), 12'h1);
    $display("test idle done");
  endtask : t_idle
  task automatic t_sigdet();
    // detect only with enable and raw detect both set
    for (int i = 0; i < 4; i++) begin
      {sig_det_en, sig_det_raw} = 2'(i);
      @(negedge clk_sys);
      check(12'(sig_det), 12'(i == 3));
    end
    $display("test sigdet done");
  endtask : t_sigdet
  task automatic t_bypass();
    lowlat_en = 1'b1;
    i_link.stall = 1'b0;
    for (int w = 0; w < 2; w++) begin
      width_10b = w[0];
      i_link.got.delete();
      i_link.send(10'h3a5);
      i_link.release_link();
      for (int i = 0; i < 20 && i_link.got.size() == 0; i++) @(negedge clk_sys);
      check(i_link.got[0], (w == 1) ? 12'h3a5 : 12'h0a5);
    end
    lowlat_en = 1'b0;
    width_10b = 1'b1;
    $display("test bypass done");
  endtask : t_bypass
  // stalled fill, then release and drain until the empty fill word
  task automatic t_stream(input int pre, input int nsk, input int post);
    logic [7:0] d;
    logic [11:0] e;
    i_link.got.delete();
    i_link.stall = 1'b1;
    for (int i = 0; i < pre; i++) i_link.send({2'b00, 8'(i)});
    for (int i = 0; i < nsk; i++) i_link.send({1'b0, SKIP});
    i_link.stall = 1'b0;
    for (int i = 0; i < post; i++) i_link.send({2'b00, 8'(pre + i)});
    i_link.release_link();
    for (int i = 0; i < 300 && !(i_link.got.size() > 0 && i_link.got[$][11]); i++)
      @(negedge clk_sys);
    d = 8'h0;
    n = 0;
    nf = 0;
    for (int i = 0; i < i_link.got.size() - 1; i++) begin
      e = i_link.got[i];
      check(12'(e[11]), 12'h0);
      if (e[8:0] === SKIP) n++;
      else begin
        check(12'(e[10]), 12'(e[7:0] !== d));
        nf += e[10];
        d = e[7:0] + 8'h1;
      end
    end
    check(i_link.got[$], 12'h9fe);
  endtask : t_stream
  // overfill while stalled: bytes are dropped and the next one is flagged
  task automatic t_drop();
    t_stream(20, 0, 2);
    check(12'(nf != 0), 12'h1);
    $display("test drop done");
  endtask : t_drop
  // long skip cluster at a high level: some skips removed, at least two kept
  task automatic t_delete();
    t_stream(12, 6, 14);
    check(12'(n >= 2 && n < 6), 12'h1);
    $display("test delete done");
  endtask : t_delete
  // lone skip near empty: repeated up to the cluster limit
  task automatic t_insert();
    t_stream(8, 1, 2);
    check(12'(n >= 2 && n <= 5), 12'h1);
    $display("test insert done");
  endtask : t_insert
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    arst_n = 1'b0;
    lowlat_en = 1'b0;
    width_10b = 1'b1;
    tx_elec_idle = 1'b0;
    sig_det_en = 1'b0;
    sig_det_raw = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(12'({out_valid, rm_full, rm_empty, tx_drv_oe, in_ready}), 12'h001);
    arst_n = 1'b1;
    @(negedge clk_sys);
    t_idle();
    t_sigdet();
    t_bypass();
    t_drop();
    t_delete();
    t_insert();
    tally_and_finish();
  end
endmodule : basic_mode_pcs_rate_match_bench
